// ---- src/uart_link_pkg.sv ----
// Shared constants and types for the host/device flow-controlled serial link
package uart_link_pkg;

    // ***********************************
    // Clock and bit timing
    // ***********************************
    localparam int CLK_HZ = 20_000_000;
    localparam int BAUD_RATE = 115_200;
    // Rounded divider keeps generated rate well inside one percent
    localparam int BIT_CYC_I = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
    localparam logic [8:0] BIT_CYC = 9'(BIT_CYC_I);
    localparam logic [8:0] HALF_BIT = 9'(BIT_CYC_I / 2);
    localparam logic [3:0] FRAME_BITS = 4'hA;
    localparam logic [3:0] STOP_IDX = 4'h9;
    localparam logic [3:0] START_IDX = 4'h0;
    localparam logic [3:0] FIRST_BIT = 4'h1;

    // ***********************************
    // Handshake spacing
    // ***********************************
    localparam logic [1:0] MODE4_HOLD_BITS = 2'h2;
    localparam logic [1:0] TX_GAP_BITS = 2'h1;
    localparam int RX_INTERPKT_MS = 20;
    localparam int RX_INTERPKT_CYC = RX_INTERPKT_MS * (CLK_HZ / 1000);

    // ***********************************
    // Buffer and line levels
    // ***********************************
    localparam int BUF_DEPTH_I = 2;
    localparam logic [1:0] BUF_DEPTH = 2'(BUF_DEPTH_I);
    localparam logic LINE_IDLE = 1'b1;
    localparam logic START_BIT = 1'b0;
    localparam logic STOP_BIT = 1'b1;
    localparam logic FLOW_ON = 1'b0;
    localparam logic FLOW_OFF = 1'b1;

    typedef enum logic [1:0] {
        HS_MODE1 = 2'h0,
        HS_MODE2 = 2'h1,
        HS_MODE3 = 2'h2,
        HS_MODE4 = 2'h3
    } hs_mode_t;

endpackage : uart_link_pkg

// ---- src/uart_link_if.sv ----
// Serial data and flow-control wires between host and device
`timescale 1ns/1ps
interface uart_link_if;
    logic host_txd;
    logic dev_txd;
    logic host_to_dev_request_n;
    logic dev_receive_grant_n;
    logic dev_to_host_request_n;
    logic host_receive_grant_n;

    modport device (
        input host_txd,
        input host_to_dev_request_n,
        input host_receive_grant_n,
        output dev_txd,
        output dev_receive_grant_n,
        output dev_to_host_request_n
    );

    modport host (
        output host_txd,
        output host_to_dev_request_n,
        output host_receive_grant_n,
        input dev_txd,
        input dev_receive_grant_n,
        input dev_to_host_request_n
    );
endinterface : uart_link_if

// ---- src/uart_dev_end.sv ----
// Device end of the flow-controlled serial link
`timescale 1ns/1ps

// Function
// - Receiver tolerates two percent baud error
// - Transmit rate within one percent
// - Receive grant follows request within 2 ms
// - Host starts first byte within 20 ms
// - Host drops request within 22 ms
// - Host grants transmit within 22 ms
// - Mode 2: host drops grant after request
// - Mode 4: request held two bits after grant
// - Byte starts within two bits of grant
// - Request drops within one bit after packet
// - Host inter-byte gap at most 100 ms
// - Host inter-packet gap at least 20 ms
// - One idle bit between transmitted packets
// - Grant loss never cuts a byte short
module uart_dev_end
    import uart_link_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Link to host
    uart_link_if.device link,
    // Handshake variant
    input wire hs_mode_t tx_mode,
    // Transmit stream
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic tx_busy,
    // Receive stream
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overrun,
    output logic rx_frame_err
);

    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_REQ = 5'h02,
        TX_SEND = 5'h04,
        TX_HOLD = 5'h08,
        TX_GAP = 5'h10
    } dtx_state_t;

    // ***********************************
    // Bit-rate divider
    // ***********************************
    logic [8:0] div_r;
    logic tick_r;
    logic div_wrap;
    assign div_wrap = (div_r == BIT_CYC - 9'h001);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else begin
            div_r <= div_wrap ? '0 : div_r + 9'h001;
            tick_r <= div_wrap;
        end
    end

    // ***********************************
    // Two-entry transmit buffer
    // ***********************************
    // Holds bytes while the host withholds its grant; nothing is dropped
    logic [8:0] buf_mem_r [BUF_DEPTH_I];
    logic buf_wp_r;
    logic buf_rp_r;
    logic [1:0] buf_cnt_r;
    logic [1:0] buf_cnt_nxt;
    logic tx_ready_r;
    logic push;
    logic pop;
    logic buf_valid;
    logic [8:0] head;
    assign push = tx_valid && tx_ready_r;
    assign buf_valid = (buf_cnt_r != 2'h0);
    assign head = buf_mem_r[buf_rp_r];
    assign buf_cnt_nxt = buf_cnt_r + {1'b0, push} - {1'b0, pop};

    for (genvar i = 0; i < BUF_DEPTH_I; i++) begin : g_buf
        always_ff @(posedge mclk) begin
            if (push && buf_wp_r == 1'(i)) begin
                buf_mem_r[i] <= {tx_last, tx_data};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            buf_wp_r <= 1'b0;
            buf_rp_r <= 1'b0;
            buf_cnt_r <= '0;
            tx_ready_r <= 1'b0;
        end else begin
            buf_wp_r <= buf_wp_r ^ push;
            buf_rp_r <= buf_rp_r ^ pop;
            buf_cnt_r <= buf_cnt_nxt;
            tx_ready_r <= (buf_cnt_nxt != BUF_DEPTH);
        end
    end

    // ***********************************
    // Transmit handshake and framing
    // ***********************************
    dtx_state_t tx_st_r, tx_st_nxt;
    logic req_n_r, req_n_nxt;
    logic txd_r, txd_nxt;
    logic [8:0] sh_r, sh_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic last_r, last_nxt;
    logic [1:0] gap_r, gap_nxt;
    logic [1:0] gneg_r;
    logic tx_busy_r;
    logic grant_on;
    logic hold_done;
    assign grant_on = (link.host_receive_grant_n == FLOW_ON);
    // Mode 4 keeps asking two full bit periods past grant loss; first tick is partial
    assign hold_done = (tx_mode != HS_MODE4) || (!grant_on && gneg_r == MODE4_HOLD_BITS + 2'h1);

    always_comb begin
        tx_st_nxt = tx_st_r;
        req_n_nxt = req_n_r;
        txd_nxt = txd_r;
        sh_nxt = sh_r;
        bit_nxt = bit_r;
        last_nxt = last_r;
        gap_nxt = gap_r;
        pop = 1'b0;
        unique case (tx_st_r)
            TX_IDLE: begin
                // Wait for the previous grant to clear before a new packet
                if (buf_valid && !grant_on) begin
                    req_n_nxt = FLOW_ON;
                    tx_st_nxt = TX_REQ;
                end
            end
            TX_REQ: begin
                if (tick_r && grant_on && buf_valid) begin
                    pop = 1'b1;
                    txd_nxt = START_BIT;
                    sh_nxt = {STOP_BIT, head[7:0]};
                    last_nxt = head[8];
                    bit_nxt = FIRST_BIT;
                    tx_st_nxt = TX_SEND;
                end
            end
            TX_SEND: begin
                if (tick_r) begin
                    if (bit_r != FRAME_BITS) begin
                        txd_nxt = sh_r[0];
                        sh_nxt = {LINE_IDLE, sh_r[8:1]};
                        bit_nxt = bit_r + 4'h1;
                    end else if (!last_r) begin
                        tx_st_nxt = TX_REQ;
                    end else if (hold_done) begin
                        req_n_nxt = FLOW_OFF;
                        gap_nxt = '0;
                        tx_st_nxt = TX_GAP;
                    end else begin
                        tx_st_nxt = TX_HOLD;
                    end
                end
            end
            TX_HOLD: begin
                if (hold_done) begin
                    req_n_nxt = FLOW_OFF;
                    gap_nxt = '0;
                    tx_st_nxt = TX_GAP;
                end
            end
            TX_GAP: begin
                if (tick_r) begin
                    gap_nxt = gap_r + 2'h1;
                    if (gap_r + 2'h1 == TX_GAP_BITS) begin
                        tx_st_nxt = TX_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tx_st_r <= TX_IDLE;
            req_n_r <= FLOW_OFF;
            txd_r <= LINE_IDLE;
            sh_r <= '1;
            bit_r <= '0;
            last_r <= 1'b0;
            gap_r <= '0;
            tx_busy_r <= 1'b0;
        end else begin
            tx_st_r <= tx_st_nxt;
            req_n_r <= req_n_nxt;
            txd_r <= txd_nxt;
            sh_r <= sh_nxt;
            bit_r <= bit_nxt;
            last_r <= last_nxt;
            gap_r <= gap_nxt;
            tx_busy_r <= (tx_st_nxt != TX_IDLE);
        end
    end

    // Bit periods since the grant went away, saturating
    always_ff @(posedge mclk) begin
        if (sys_rst || grant_on) begin
            gneg_r <= '0;
        end else if (tick_r && gneg_r != MODE4_HOLD_BITS + 2'h1) begin
            gneg_r <= gneg_r + 2'h1;
        end
    end

    // ***********************************
    // Receiver
    // ***********************************
    logic rx_busy_r;
    logic [8:0] rx_cnt_r;
    logic [3:0] rx_idx_r;
    logic [7:0] rx_sh_r;
    logic rxd_prev_r;
    logic [7:0] rx_data_r;
    logic rx_valid_r;
    logic rx_ovr_r;
    logic rx_ferr_r;
    logic gnt_n_r;
    logic rxd;
    logic rx_start;
    logic rx_samp;
    logic rx_done;
    logic rx_abort;
    logic rx_good;
    assign rxd = link.host_txd;
    assign rx_start = !rx_busy_r && rxd_prev_r == LINE_IDLE && rxd == START_BIT;
    assign rx_samp = rx_busy_r && rx_cnt_r == 9'h000;
    assign rx_done = rx_samp && rx_idx_r == STOP_IDX;
    assign rx_abort = rx_samp && rx_idx_r == START_IDX && rxd != START_BIT;
    assign rx_good = rx_done && rxd == STOP_BIT;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_busy_r <= 1'b0;
            rx_cnt_r <= '0;
            rx_idx_r <= '0;
            rx_sh_r <= '0;
            rxd_prev_r <= LINE_IDLE;
        end else begin
            rxd_prev_r <= rxd;
            if (rx_start) begin
                // Mid-bit sampling from the start edge absorbs two percent drift
                rx_busy_r <= 1'b1;
                rx_cnt_r <= HALF_BIT;
                rx_idx_r <= START_IDX;
            end else if (rx_samp) begin
                rx_busy_r <= !(rx_done || rx_abort);
                rx_cnt_r <= BIT_CYC - 9'h001;
                rx_idx_r <= rx_idx_r + 4'h1;
                if (rx_idx_r != START_IDX && rx_idx_r != STOP_IDX) begin
                    rx_sh_r <= {rxd, rx_sh_r[7:1]};
                end
            end else if (rx_busy_r) begin
                rx_cnt_r <= rx_cnt_r - 9'h001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_data_r <= '0;
            rx_valid_r <= 1'b0;
            rx_ovr_r <= 1'b0;
            rx_ferr_r <= 1'b0;
            gnt_n_r <= FLOW_OFF;
        end else begin
            // New byte wins over a same-cycle take
            if (rx_good && (!rx_valid_r || rx_ready)) begin
                rx_data_r <= rx_sh_r;
                rx_valid_r <= 1'b1;
            end else if (rx_ready) begin
                rx_valid_r <= 1'b0;
            end
            rx_ovr_r <= rx_good && rx_valid_r && !rx_ready;
            rx_ferr_r <= rx_done && rxd != STOP_BIT;
            gnt_n_r <= link.host_to_dev_request_n;
        end
    end

    // ***********************************
    // Outputs
    // ***********************************
    assign link.dev_txd = txd_r;
    assign link.dev_to_host_request_n = req_n_r;
    assign link.dev_receive_grant_n = gnt_n_r;
    assign tx_ready = tx_ready_r;
    assign tx_busy = tx_busy_r;
    assign rx_data = rx_data_r;
    assign rx_valid = rx_valid_r;
    assign rx_overrun = rx_ovr_r;
    assign rx_frame_err = rx_ferr_r;

endmodule : uart_dev_end

// ---- src/uart_host_end.sv ----
// Host end of the flow-controlled serial link
`timescale 1ns/1ps
module uart_host_end
    import uart_link_pkg::*;
#(
    parameter int GAP_CYC = RX_INTERPKT_CYC
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Link to device
    uart_link_if.host link,
    // Transmit stream
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_valid,
    output logic tx_ready,
    // Receive stream
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_frame_err
);

    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_REQ = 4'h2,
        H_SEND = 4'h4,
        H_GAP = 4'h8
    } htx_state_t;

    // ***********************************
    // Bit-rate divider
    // ***********************************
    logic [8:0] div_r;
    logic tick_r;
    logic div_wrap;
    assign div_wrap = (div_r == BIT_CYC - 9'h001);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else begin
            div_r <= div_wrap ? '0 : div_r + 9'h001;
            tick_r <= div_wrap;
        end
    end

    // ***********************************
    // Transmit path
    // ***********************************
    htx_state_t st_r;
    logic [8:0] hold_r;
    logic hold_v_r;
    logic tx_ready_r;
    logic req_n_r;
    logic txd_r;
    logic [8:0] sh_r;
    logic [3:0] bit_r;
    logic last_r;
    logic [18:0] gap_r;
    logic load;
    logic start;
    logic grant_on;
    assign load = tx_valid && tx_ready_r;
    assign grant_on = (link.dev_receive_grant_n == FLOW_ON);
    // Bytes go out at the next bit tick, far inside the 20 ms allowance
    assign start = (st_r == H_REQ) && tick_r && grant_on && hold_v_r;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hold_r <= '0;
            hold_v_r <= 1'b0;
            tx_ready_r <= 1'b0;
        end else begin
            if (load) begin
                hold_r <= {tx_last, tx_data};
            end
            hold_v_r <= load || (hold_v_r && !start);
            tx_ready_r <= !(load || (hold_v_r && !start));
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= H_IDLE;
            req_n_r <= FLOW_OFF;
            txd_r <= LINE_IDLE;
            sh_r <= '1;
            bit_r <= '0;
            last_r <= 1'b0;
            gap_r <= '0;
        end else begin
            unique case (st_r)
                H_IDLE: begin
                    if (hold_v_r) begin
                        req_n_r <= FLOW_ON;
                        st_r <= H_REQ;
                    end
                end
                H_REQ: begin
                    if (start) begin
                        txd_r <= START_BIT;
                        sh_r <= {STOP_BIT, hold_r[7:0]};
                        last_r <= hold_r[8];
                        bit_r <= FIRST_BIT;
                        st_r <= H_SEND;
                    end
                end
                H_SEND: begin
                    if (tick_r) begin
                        if (bit_r != FRAME_BITS) begin
                            txd_r <= sh_r[0];
                            sh_r <= {LINE_IDLE, sh_r[8:1]};
                            bit_r <= bit_r + 4'h1;
                        end else if (!last_r) begin
                            st_r <= H_REQ;
                        end else begin
                            req_n_r <= FLOW_OFF;
                            gap_r <= '0;
                            st_r <= H_GAP;
                        end
                    end
                end
                H_GAP: begin
                    if (gap_r == 19'(GAP_CYC - 1)) begin
                        st_r <= H_IDLE;
                    end else begin
                        gap_r <= gap_r + 19'h00001;
                    end
                end
            endcase
        end
    end

    // ***********************************
    // Receive path
    // ***********************************
    logic rx_busy_r;
    logic [8:0] rx_cnt_r;
    logic [3:0] rx_idx_r;
    logic [7:0] rx_sh_r;
    logic rxd_prev_r;
    logic [7:0] rx_data_r;
    logic rx_valid_r;
    logic rx_ferr_r;
    logic gnt_n_r;
    logic rxd;
    logic rx_start;
    logic rx_samp;
    logic rx_done;
    logic rx_abort;
    logic dev_req_on;
    assign rxd = link.dev_txd;
    assign dev_req_on = (link.dev_to_host_request_n == FLOW_ON);
    assign rx_start = !rx_busy_r && rxd_prev_r == LINE_IDLE && rxd == START_BIT;
    assign rx_samp = rx_busy_r && rx_cnt_r == 9'h000;
    assign rx_done = rx_samp && rx_idx_r == STOP_IDX;
    assign rx_abort = rx_samp && rx_idx_r == START_IDX && rxd != START_BIT;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_busy_r <= 1'b0;
            rx_cnt_r <= '0;
            rx_idx_r <= '0;
            rx_sh_r <= '0;
            rxd_prev_r <= LINE_IDLE;
        end else begin
            rxd_prev_r <= rxd;
            if (rx_start) begin
                rx_busy_r <= 1'b1;
                rx_cnt_r <= HALF_BIT;
                rx_idx_r <= START_IDX;
            end else if (rx_samp) begin
                rx_busy_r <= !(rx_done || rx_abort);
                rx_cnt_r <= BIT_CYC - 9'h001;
                rx_idx_r <= rx_idx_r + 4'h1;
                if (rx_idx_r != START_IDX && rx_idx_r != STOP_IDX) begin
                    rx_sh_r <= {rxd, rx_sh_r[7:1]};
                end
            end else if (rx_busy_r) begin
                rx_cnt_r <= rx_cnt_r - 9'h001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_data_r <= '0;
            rx_valid_r <= 1'b0;
            rx_ferr_r <= 1'b0;
            gnt_n_r <= FLOW_OFF;
        end else begin
            if (rx_done && rxd == STOP_BIT) begin
                rx_data_r <= rx_sh_r;
                rx_valid_r <= 1'b1;
            end else if (rx_ready) begin
                rx_valid_r <= 1'b0;
            end
            rx_ferr_r <= rx_done && rxd != STOP_BIT;
            // One byte in flight only: grant drops at each start bit
            // and returns once the byte is taken, so none is lost
            gnt_n_r <= (dev_req_on && !rx_valid_r && !rx_busy_r && !rx_start) ? FLOW_ON : FLOW_OFF;
        end
    end

    // ***********************************
    // Outputs
    // ***********************************
    assign link.host_txd = txd_r;
    assign link.host_to_dev_request_n = req_n_r;
    assign link.host_receive_grant_n = gnt_n_r;
    assign tx_ready = tx_ready_r;
    assign rx_data = rx_data_r;
    assign rx_valid = rx_valid_r;
    assign rx_frame_err = rx_ferr_r;

endmodule : uart_host_end

// ---- tb/uart_link_checker.sv ----
// Wire checks on the host/device serial link
`timescale 1ns/1ps
module uart_link_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Link wires
    input wire logic host_txd,
    input wire logic dev_txd,
    input wire logic host_to_dev_request_n,
    input wire logic dev_receive_grant_n,
    input wire logic dev_to_host_request_n,
    input wire logic host_receive_grant_n
);
    localparam int BIT = uart_link_pkg::BIT_CYC_I;
    localparam int TWO_BITS = 2 * BIT;
    logic busy_r;
    logic [10:0] cnt_r;
    logic [8:0] idle_r;
    logic [8:0] ghi_r;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // ***
    // Frame trackers
    // ***
    // Idle and grant-off counters saturate so a long idle never wraps; the frame counter stops at frame end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
            cnt_r <= 11'h0;
        end else if (!busy_r && !dev_txd) begin
            busy_r <= 1'b1;
            cnt_r <= 11'h1;
        end else if (busy_r) begin
            busy_r <= cnt_r != 11'(10 * BIT - 1);
            cnt_r <= cnt_r + 11'h1;
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            idle_r <= 9'h1FF;
        end else if (busy_r) begin
            idle_r <= 9'h0;
        end else if (idle_r != 9'h1FF) begin
            idle_r <= idle_r + 9'h1;
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst || !host_receive_grant_n) begin
            ghi_r <= 9'h0;
        end else if (ghi_r != 9'h1FF) begin
            ghi_r <= ghi_r + 9'h1;
        end
    end
    // ***
    // Assertions
    // ***
    a_idle_at_reset: assert property (
        $fell(sys_rst) |-> &{dev_txd, host_txd, dev_receive_grant_n, dev_to_host_request_n, host_receive_grant_n})
        else $error("link not idle after reset");
    a_grant_follows: assert property (
        !$stable(host_to_dev_request_n) |=> dev_receive_grant_n == $past(host_to_dev_request_n))
        else $error("grant missed request");
    a_grant_only_req: assert property (
        !$stable(dev_receive_grant_n) |-> dev_receive_grant_n == $past(host_to_dev_request_n))
        else $error("grant moved alone");
    a_start_width: assert property (
        busy_r && cnt_r < 11'(BIT) |-> !dev_txd) else $error("start bit short");
    a_stop_tail: assert property (
        busy_r && cnt_r >= 11'(9 * BIT) |-> dev_txd) else $error("stop bit wrong");
    a_tx_gap: assert property (
        !busy_r && !dev_txd |-> idle_r >= 9'(BIT - 1)) else $error("idle gap short");
    a_start_needs_req: assert property (
        !busy_r && !dev_txd |-> !dev_to_host_request_n) else $error("byte without request");
    a_start_after_grant: assert property (
        $fell(host_receive_grant_n) && !dev_to_host_request_n |-> ##[1:TWO_BITS]
        (busy_r || dev_to_host_request_n || host_receive_grant_n)) else $error("byte late after grant");
    a_req_release: assert property (
        $rose(dev_to_host_request_n) |->
        (busy_r ? cnt_r >= 11'(9 * BIT) : (idle_r <= 9'(BIT + 1) || ghi_r >= 9'(TWO_BITS))))
        else $error("request released wrongly");
    c_frame: cover property (!busy_r && !dev_txd);
    c_release: cover property ($rose(dev_to_host_request_n));
    c_host_byte: cover property ($fell(host_txd));
endmodule : uart_link_checker

// ---- tb/host_uart_flow_handshake_tb.sv ----
// Bench joining the device and host ends
`timescale 1ns/1ps
module host_uart_flow_handshake_tb;
    import uart_link_pkg::*;
    logic mclk, sys_rst, saw_full, h_hold, stall_on;
    hs_mode_t tx_mode;
    logic [7:0] d_td, d_rd, h_td, h_rd;
    logic d_tl, d_tv, d_tr, d_bz, d_rv, d_rr, d_ov, d_fe, h_tl, h_tv, h_tr, h_rv, h_rr, h_fe;
    int err_total, n_compared, seed, w;
    logic [7:0] qh[$];
    logic [7:0] qd[$];
    uart_link_if link ();
    uart_dev_end i_uart_dev_end (.mclk(mclk), .sys_rst(sys_rst), .link(link.device), .tx_mode(tx_mode),
        .tx_data(d_td), .tx_last(d_tl), .tx_valid(d_tv), .tx_ready(d_tr), .tx_busy(d_bz), .rx_data(d_rd),
        .rx_valid(d_rv), .rx_ready(d_rr), .rx_overrun(d_ov), .rx_frame_err(d_fe));
    uart_host_end #(.GAP_CYC(400)) i_uart_host_end (.mclk(mclk), .sys_rst(sys_rst), .link(link.host),
        .tx_data(h_td), .tx_last(h_tl), .tx_valid(h_tv), .tx_ready(h_tr), .rx_data(h_rd), .rx_valid(h_rv),
        .rx_ready(h_rr), .rx_frame_err(h_fe));
    uart_link_checker i_uart_link_checker (.mclk(mclk), .sys_rst(sys_rst), .host_txd(link.host_txd),
        .dev_txd(link.dev_txd), .host_to_dev_request_n(link.host_to_dev_request_n),
        .dev_receive_grant_n(link.dev_receive_grant_n), .dev_to_host_request_n(link.dev_to_host_request_n),
        .host_receive_grant_n(link.host_receive_grant_n));
    // ***
    // Tasks
    // ***
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h0, got}, {7'h0, exp});
    endtask : chk_bit
    // Every wait is bounded; running out ends the run
    task automatic bump(inout int n);
        n++;
        if (n > 40000) begin
            err_total++;
            stop_test();
        end
    endtask : bump
    task automatic send(input bit to_host, input int n);
        logic [7:0] b;
        int k;
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed));
            k = 0;
            @(negedge mclk);
            if (to_host) begin
                qh.push_back(b);
                d_td = b;
                d_tl = (i == n - 1);
                d_tv = 1'b1;
            end else begin
                qd.push_back(b);
                h_td = b;
                h_tl = (i == n - 1);
                h_tv = 1'b1;
            end
            // Ready is settled by the falling edge; the transfer is the next rising one
            while ((to_host ? d_tr : h_tr) !== 1'b1) begin
                @(negedge mclk);
                bump(k);
            end
            @(posedge mclk);
            saw_full |= to_host && k > 0;
        end
        @(negedge mclk);
        if (to_host) d_tv = 1'b0;
        else h_tv = 1'b0;
    endtask : send
    task automatic drain(input string name);
        int k;
        k = 0;
        while (qh.size() + qd.size() != 0 || d_bz !== 1'b0) begin
            @(negedge mclk);
            bump(k);
        end
        $display("test %s done", name);
    endtask : drain
    // ***
    // Model checks and stimulus
    // ***
    always @(posedge mclk) begin
        if (!sys_rst && h_rv === 1'b1 && h_rr === 1'b1) begin
            chk_byte(h_rd, qh.size() > 0 ? qh.pop_front() : 8'hXX);
        end
        if (!sys_rst && d_rv === 1'b1 && d_rr === 1'b1) begin
            chk_byte(d_rd, qd.size() > 0 ? qd.pop_front() : 8'hXX);
        end
        if (!sys_rst && (d_ov | d_fe | h_fe) !== 1'b0) begin
            chk_bit(d_ov | d_fe | h_fe, 1'b0);
        end
    end
    always @(negedge mclk) begin
        h_rr <= !h_hold && (!stall_on || 1'($random(seed)));
        d_rr <= !stall_on || 1'($random(seed));
    end
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        seed = 87151;
        err_total = 0;
        n_compared = 0;
        saw_full = 1'b0;
        h_hold = 1'b0;
        stall_on = 1'b0;
        sys_rst = 1'b1;
        tx_mode = HS_MODE1;
        {d_td, d_tl, d_tv, h_td, h_tl, h_tv} = '0;
        repeat (5) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        chk_bit(d_tr, 1'b1);
        chk_bit(link.dev_to_host_request_n, FLOW_OFF);
        chk_bit(link.host_receive_grant_n, FLOW_OFF);
        for (int m = 0; m < 3; m++) begin
            tx_mode = hs_mode_t'(m);
            stall_on = (m == 2);
            send(1'b1, 3);
            drain("device packet");
        end
        // Host keeps the byte so its grant stays off at packet end
        tx_mode = HS_MODE4;
        h_hold = 1'b1;
        send(1'b1, 1);
        w = 0;
        while (h_rv !== 1'b1 || link.dev_to_host_request_n !== FLOW_OFF) begin
            @(negedge mclk);
            bump(w);
        end
        chk_bit(link.host_receive_grant_n, FLOW_OFF);
        h_hold = 1'b0;
        drain("hold variant");
        tx_mode = HS_MODE2;
        stall_on = 1'b1;
        fork
            send(1'b0, 2);
            send(1'b1, 4);
        join
        send(1'b0, 3);
        drain("both directions");
        chk_bit(saw_full, 1'b1);
        stop_test();
    end
endmodule : host_uart_flow_handshake_tb
